// [verilog/ccu_channel.sv]
/*
  One capture/compare channel with an APB register port.
  Assumes the timebase end supplies a synchronous count and a synchronised pin level.
*/
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// Function
// (RL1) Capture loads full 16-bit timer count
// (RL2) Mode picks falling, rising, 4th, 16th, any
// (RL3) Capture sets flag; software clears it
// (RL4) New capture overwrites unread value
// (RL5) Reader disables channel or reads twice
// (RL6) Source select field picks capture input
// (RL7) Pin level observed even when output
// (RL8) Mode change may raise false interrupt
// (RL9) Prescaler cleared on reset, off, non-capture
// (RL10) Prescale change keeps prescaler count
// (RL11) Timer must count synchronously
// (RL12) Timer clock is instruction or external
// (RL13) Capture works whenever timer keeps counting
// (RL14) Compare value against timer count continuously
// (RL15) Match action selected by mode field
// (RL16) Modes 0001 and 1011 clear timer
// (RL17) Every compare match sets flag
// (RL18) Zero control write forces output low
// (RL19) Output driver optionally open-drain
// (RL20) Capture/compare use the 16-bit timebase
// (RL21) Value reachable as two byte halves
// (RL22) Enabled match interrupt wakes device
// (RL23) Prescaler strobes at divisor, restarts
module ccu_channel
  import ccu_pkg::*;
(
  input  wire logic   pclk,
  input  wire logic   presetn,
  input  wire logic   psel,
  input  wire logic   penable,
  input  wire logic   pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  input  wire logic [2:0]  cap_src_in,
  output logic        irq,
  ccu_link_if.channel link
);
  import ccu_pkg::*;

  logic [7:0]  ctrl_q;
  logic [7:0]  capsel_q;
  logic [15:0] val_q;
  logic        flag_q;
  logic        irq_en_q;
  logic        out_q;
  logic [3:0]  presc_q;
  logic [1:0]  pulse_q;
  logic        src_prev_q;
  logic        match_prev_q;
  logic [31:0] rdata_q;

  ccu_mode_t   mode;
  logic        en;
  logic        is_cap;
  logic        is_cmp;
  logic        src;
  logic        rise;
  logic        fall;
  logic        cap_strobe;
  logic        match;
  logic        hit;
  logic        wr;
  logic        rd_setup;
  logic        mapped;
  logic        presc_last;
  logic        presc_mode;

  assign mode = ccu_mode_t'(ctrl_q[3:0]);
  assign en   = ctrl_q[CCU_CTRL_EN_BIT];

  always_comb begin
    is_cap = 1'b0;
    is_cmp = 1'b0;
    unique case (mode)
      CCU_MODE_CAP_ANY, CCU_MODE_CAP_FALL, CCU_MODE_CAP_RISE,
      CCU_MODE_CAP_R4, CCU_MODE_CAP_R16: is_cap = 1'b1;
      CCU_MODE_CMP_TGLCL, CCU_MODE_CMP_TGL, CCU_MODE_CMP_SET,
      CCU_MODE_CMP_CLR, CCU_MODE_CMP_PULSE, CCU_MODE_CMP_PLSCL: is_cmp = 1'b1;
      default: begin
        is_cap = 1'b0;
        is_cmp = 1'b0;
      end
    endcase
  end

  // APB decode; zero-wait access phase
  always_comb begin
    unique case (paddr)
      CCU_OFF_CTRL, CCU_OFF_CAPSEL, CCU_OFF_VAL_LO,
      CCU_OFF_VAL_HI, CCU_OFF_IRQ_REQ, CCU_OFF_IRQ_EN: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~mapped;
  assign wr       = psel & penable & pwrite & mapped;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign prdata   = rdata_q;

  // Read data sampled in setup, held through access; halves may differ by an event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_setup) begin
      unique case (paddr)
        CCU_OFF_CTRL:    rdata_q <= {24'h00_0000, ctrl_q[7:6], out_q, ctrl_q[4:0]};
        CCU_OFF_CAPSEL:  rdata_q <= {24'h00_0000, capsel_q};
        CCU_OFF_VAL_LO:  rdata_q <= {24'h00_0000, val_q[7:0]};  // RL21 RL5
        CCU_OFF_VAL_HI:  rdata_q <= {24'h00_0000, val_q[15:8]}; // RL21 RL5
        CCU_OFF_IRQ_REQ: rdata_q <= {31'h0000_0000, flag_q};
        CCU_OFF_IRQ_EN:  rdata_q <= {31'h0000_0000, irq_en_q};
        default:         rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q   <= CCU_CTRL_RST;
      capsel_q <= CCU_CAPSEL_RST;
      irq_en_q <= 1'b0;
    end else if (wr) begin
      if (paddr == CCU_OFF_CTRL) begin
        ctrl_q <= pwdata[7:0];
      end
      if (paddr == CCU_OFF_CAPSEL) begin
        capsel_q <= pwdata[7:0];
      end
      if (paddr == CCU_OFF_IRQ_EN) begin
        irq_en_q <= pwdata[CCU_IRQ_EN_BIT];
      end
    end
  end

  // Capture source mux; 0 is the channel pin, even while it drives
  always_comb begin
    unique case (capsel_q[1:0])
      2'h0: src = link.pin_level; // RL7
      2'h1: src = cap_src_in[0];
      2'h2: src = cap_src_in[1];
      2'h3: src = cap_src_in[2];
    endcase
  end // RL6

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_prev_q <= 1'b0;
    end else begin
      src_prev_q <= src;
    end
  end
  // Edge history runs in every mode, so a mode change can fire at once
  assign rise = src & ~src_prev_q; // RL8
  assign fall = ~src & src_prev_q;

  assign presc_mode = (mode == CCU_MODE_CAP_R4) || (mode == CCU_MODE_CAP_R16);
  assign presc_last = (mode == CCU_MODE_CAP_R4) ? (presc_q == CCU_DIV4_LAST)
                                                : (presc_q == CCU_DIV16_LAST);

  // Count kept across a prescale switch; only off or non-capture clears it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_q <= 4'h0; // RL9
    end else if (!en || !is_cap) begin
      presc_q <= 4'h0; // RL9
    end else if (presc_mode && rise) begin
      presc_q <= presc_last ? 4'h0 : presc_q + 4'h1; // RL23 RL10
    end
  end

  always_comb begin
    cap_strobe = 1'b0;
    if (en) begin
      unique case (mode)
        CCU_MODE_CAP_FALL: cap_strobe = fall;
        CCU_MODE_CAP_RISE: cap_strobe = rise;
        CCU_MODE_CAP_R4, CCU_MODE_CAP_R16: cap_strobe = rise & presc_last; // RL23
        CCU_MODE_CAP_ANY:  cap_strobe = rise | fall;
        default:           cap_strobe = 1'b0;
      endcase
    end
  end // RL2

  // Compare fires once as the count arrives at the value
  assign match = en & is_cmp & (val_q == link.timebase_count); // RL14 RL20
  assign hit   = match & ~match_prev_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_prev_q <= 1'b0;
    end else begin
      match_prev_q <= match;
    end
  end

  // Capture overwrites; software writes load the compare value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      val_q <= CCU_VAL_RST;
    end else if (cap_strobe) begin
      val_q <= link.timebase_count; // RL1 RL4 RL13
    end else if (wr && paddr == CCU_OFF_VAL_LO) begin
      val_q[7:0] <= pwdata[7:0]; // RL21
    end else if (wr && paddr == CCU_OFF_VAL_HI) begin
      val_q[15:8] <= pwdata[7:0]; // RL21
    end
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= 1'b0;
    end else if (cap_strobe || hit) begin
      flag_q <= 1'b1; // RL3 RL17
    end else if (wr && paddr == CCU_OFF_IRQ_REQ && pwdata[CCU_IRQ_FLAG_BIT]) begin
      flag_q <= 1'b0; // RL3
    end
  end
  assign irq = flag_q & irq_en_q; // RL22

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q   <= 1'b0;
      pulse_q <= 2'h0;
    end else if (ctrl_q == 8'h00) begin
      out_q   <= 1'b0; // RL18
      pulse_q <= 2'h0;
    end else if (hit) begin
      unique case (mode)
        CCU_MODE_CMP_TGLCL, CCU_MODE_CMP_TGL: out_q <= ~out_q;
        CCU_MODE_CMP_SET: out_q <= 1'b1;
        CCU_MODE_CMP_CLR: out_q <= 1'b0;
        CCU_MODE_CMP_PULSE, CCU_MODE_CMP_PLSCL: begin
          out_q   <= 1'b1;
          pulse_q <= 2'(CCU_PULSE_CYC - 1);
        end
        default: out_q <= out_q;
      endcase // RL15
    end else if (pulse_q != 2'h0) begin
      pulse_q <= pulse_q - 2'h1;
    end else if (mode == CCU_MODE_CMP_PULSE || mode == CCU_MODE_CMP_PLSCL) begin
      out_q <= 1'b0;
    end
  end

  assign link.timebase_clear = hit & ((mode == CCU_MODE_CMP_TGLCL) ||
                                      (mode == CCU_MODE_CMP_PLSCL)); // RL16

  // Open-drain only ever pulls low; the high level comes from the pull-up
  assign link.chan_out = capsel_q[CCU_CAPSEL_OD_BIT] ? 1'b0 : out_q; // RL19
  assign link.chan_oe  = en & is_cmp & (~capsel_q[CCU_CAPSEL_OD_BIT] | ~out_q); // RL19
endmodule

// [verilog/ccu_pkg.sv]
/*
  Shared constants and types for the capture/compare channel and its timebase.
  Assumes a 25 MHz pclk and a 32-bit APB register port on the channel.
*/
package ccu_pkg;

  localparam int          CCU_CLK_HZ       = 25_000_000;
  localparam int          CCU_INSTR_DIV    = 4;
  localparam int          CCU_PULSE_CYC    = 4;

  localparam logic [7:0]  CCU_OFF_CTRL     = 8'h00;
  localparam logic [7:0]  CCU_OFF_CAPSEL   = 8'h04;
  localparam logic [7:0]  CCU_OFF_VAL_LO   = 8'h08;
  localparam logic [7:0]  CCU_OFF_VAL_HI   = 8'h0C;
  localparam logic [7:0]  CCU_OFF_IRQ_REQ  = 8'h10;
  localparam logic [7:0]  CCU_OFF_IRQ_EN   = 8'h14;

  localparam int          CCU_CTRL_EN_BIT  = 7;
  localparam int          CCU_CTRL_OUT_BIT = 5;
  localparam int          CCU_CTRL_FMT_BIT = 4;
  localparam int          CCU_CAPSEL_OD_BIT = 7;
  localparam int          CCU_IRQ_FLAG_BIT = 0;
  localparam int          CCU_IRQ_EN_BIT   = 0;

  localparam logic [7:0]  CCU_CTRL_RST     = 8'h00;
  localparam logic [7:0]  CCU_CAPSEL_RST   = 8'h00;
  localparam logic [15:0] CCU_VAL_RST      = 16'h0000;

  localparam logic [3:0]  CCU_DIV4_LAST    = 4'h3;
  localparam logic [3:0]  CCU_DIV16_LAST   = 4'hF;

  typedef enum logic [3:0] {
    CCU_MODE_OFF       = 4'b0000,
    CCU_MODE_CMP_TGLCL = 4'b0001,
    CCU_MODE_CMP_TGL   = 4'b0010,
    CCU_MODE_CAP_ANY   = 4'b0011,
    CCU_MODE_CAP_FALL  = 4'b0100,
    CCU_MODE_CAP_RISE  = 4'b0101,
    CCU_MODE_CAP_R4    = 4'b0110,
    CCU_MODE_CAP_R16   = 4'b0111,
    CCU_MODE_CMP_SET   = 4'b1000,
    CCU_MODE_CMP_CLR   = 4'b1001,
    CCU_MODE_CMP_PULSE = 4'b1010,
    CCU_MODE_CMP_PLSCL = 4'b1011
  } ccu_mode_t;

endpackage

// [verilog/ccu_link_if.sv]
/*
  Link between the capture/compare channel and the timebase/pin end.
  Assumes both ends run on the same pclk; no clocking block.
*/
`timescale 1ns/1ps
interface ccu_link_if;
  logic [15:0] timebase_count;
  logic        timebase_clear;
  logic        pin_level;
  logic        chan_out;
  logic        chan_oe;

  modport channel (
    input  timebase_count,
    input  pin_level,
    output timebase_clear,
    output chan_out,
    output chan_oe
  );

  modport timebase (
    output timebase_count,
    output pin_level,
    input  timebase_clear,
    input  chan_out,
    input  chan_oe
  );
endinterface

// [verilog/ccu_timebase.sv]
/*
  Shared 16-bit timebase and channel pin end of the link.
  Assumes pad and external clock are asynchronous to pclk; pad wire resolved outside.
*/
`timescale 1ns/1ps
module ccu_timebase
  import ccu_pkg::*;
(
  input  wire logic   pclk,
  input  wire logic   presetn,
  ccu_link_if.timebase link,
  input  wire logic   tmr_run,
  input  wire logic   tmr_ext_sel,
  input  wire logic   tmr_ext_clk,
  input  wire logic   pad_in,
  output logic        pad_out,
  output logic        pad_oe
);
  import ccu_pkg::*;

  logic [1:0]  div_q;
  logic        tick_instr;
  logic [1:0]  ext_sync_q;
  logic        ext_prev_q;
  logic        tick_ext;
  logic [1:0]  pad_sync_q;
  logic [15:0] count_q;
  logic        count_en;

  // Instruction clock: pclk divided by four, never pclk itself
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 2'h0;
    end else begin
      div_q <= div_q + 2'h1;
    end
  end
  assign tick_instr = (div_q == 2'(CCU_INSTR_DIV - 1)); // RL12

  // External clock counted only after synchronising
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_sync_q <= 2'h0;
      ext_prev_q <= 1'b0;
    end else begin
      ext_sync_q <= {ext_sync_q[0], tmr_ext_clk};
      ext_prev_q <= ext_sync_q[1];
    end
  end
  assign tick_ext = ext_sync_q[1] & ~ext_prev_q; // RL11

  assign count_en = tmr_run & (tmr_ext_sel ? tick_ext : tick_instr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= 16'h0000;
    end else if (link.timebase_clear) begin
      count_q <= 16'h0000;
    end else if (count_en) begin
      count_q <= count_q + 16'h0001;
    end
  end
  assign link.timebase_count = count_q;

  // Pad level seen even while driven, so port writes can capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_sync_q <= 2'h0;
    end else begin
      pad_sync_q <= {pad_sync_q[0], pad_in};
    end
  end
  assign link.pin_level = pad_sync_q[1];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_out <= 1'b0;
      pad_oe  <= 1'b0;
    end else begin
      pad_out <= link.chan_out;
      pad_oe  <= link.chan_oe;
    end
  end
endmodule

// [bench/ccu_assertions.sv]
/* Link checker for the channel and timebase pair.
   Assumes it sits beside the link, on pclk. */
`timescale 1ns/1ps
module ccu_assertions (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [15:0] timebase_count,
  input wire logic        timebase_clear,
  input wire logic        pin_level,
  input wire logic        chan_out,
  input wire logic        chan_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_clr_zero;
    timebase_clear |=> timebase_count == 16'h0000;
  endproperty
  a_clr_zero: assert property (p_clr_zero) else $error("count not cleared");
  property p_clr_once;
    timebase_clear |=> !timebase_clear;
  endproperty
  a_clr_once: assert property (p_clr_once) else $error("clear too long");
  property p_step;
    !timebase_clear |=> (timebase_count == $past(timebase_count)) ||
      (timebase_count == $past(timebase_count) + 16'h0001);
  endproperty
  a_step: assert property (p_step) else $error("count jumped");
  // Clear may land at any prescaler phase, so skip it
  property p_spacing;
    $changed(timebase_count) && !$past(timebase_clear) |=>
      ($stable(timebase_count) || $past(timebase_clear))[*3];
  endproperty
  a_spacing: assert property (p_spacing) else $error("count too fast");
  property p_rst_out;
    $rose(presetn) |-> !chan_out;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("out high at reset");
  property p_rst_oe;
    $rose(presetn) |-> !chan_oe;
  endproperty
  a_rst_oe: assert property (p_rst_oe) else $error("driving at reset");
  property p_hold_hi;
    $rose(chan_out) |=> chan_out[*3];
  endproperty
  a_hold_hi: assert property (p_hold_hi) else $error("out high too short");
  property p_clr_act;
    timebase_clear |=> chan_out || (chan_out != $past(chan_out));
  endproperty
  a_clr_act: assert property (p_clr_act) else $error("no action on hit");
  // Driven level comes back through pad register and two sync flops
  property p_pin_echo;
    chan_oe[*4] |-> pin_level == $past(chan_out, 3);
  endproperty
  a_pin_echo: assert property (p_pin_echo) else $error("pin level not seen");
endmodule

// [bench/capture_compare_unit_tb.sv]
/* Bench: channel and timebase on one link, driven over APB.
   Assumes external timebase ticks, then the instruction tick in the last scenario. */
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module capture_compare_unit_tb;
  import ccu_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, ext = 1'b0, pad_drv = 1'b0, eo = 1'b0, tsel = 1'b1;
  logic        pready, pslverr, irq, pad_out, pad_oe, rerr;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic [2:0]  src = 3'h0;
  logic [15:0] cnt = 16'h0, er;
  int          error_cnt = 0, checks_done = 0, hi_cnt = 0;
  wire         pad_in = pad_oe ? pad_out : pad_drv;
  ccu_mode_t   cm[3] = '{CCU_MODE_CAP_FALL, CCU_MODE_CAP_RISE, CCU_MODE_CAP_ANY};
  ccu_mode_t   km[6] = '{CCU_MODE_CMP_TGLCL, CCU_MODE_CMP_TGL, CCU_MODE_CMP_SET,
                         CCU_MODE_CMP_CLR, CCU_MODE_CMP_PULSE, CCU_MODE_CMP_PLSCL};
  ccu_link_if link ();
  ccu_channel i_ccu_channel (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cap_src_in(src),
    .irq(irq), .link(link));
  ccu_timebase i_ccu_timebase (.pclk(pclk), .presetn(presetn), .link(link),
    .tmr_run(1'b1), .tmr_ext_sel(tsel), .tmr_ext_clk(ext), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe));
  ccu_assertions i_ccu_assertions (.pclk(pclk), .presetn(presetn),
    .timebase_count(link.timebase_count), .timebase_clear(link.timebase_clear),
    .pin_level(link.pin_level), .chan_out(link.chan_out), .chan_oe(link.chan_oe));
  always #20 pclk = ~pclk;
  always @(posedge pclk) if (link.chan_out === 1'b1) hi_cnt <= hi_cnt + 1;
  task automatic final_report;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    `CHK(rdat, e)
  endtask
  // Halves are not atomic; callers keep the input quiet meanwhile
  task automatic rdv(input logic [15:0] e);
    logic [7:0] lo;
    xfer(CCU_OFF_VAL_LO, 1'b0, 32'h0);
    lo = rdat[7:0];
    xfer(CCU_OFF_VAL_HI, 1'b0, 32'h0);
    `CHK({rdat[7:0], lo}, e)
  endtask
  task automatic wv(input logic [15:0] v);
    wr(CCU_OFF_VAL_LO, {24'h0, v[7:0]});
    wr(CCU_OFF_VAL_HI, {24'h0, v[15:8]});
  endtask
  // Slow ticks keep count updates eight pclk apart
  task automatic tick(input int n);
    repeat (n) begin
      ext <= 1'b1;
      repeat (4) @(posedge pclk);
      ext <= 1'b0;
      repeat (4) @(posedge pclk);
    end
    cnt = cnt + 16'(n);
  endtask
  task automatic drv(input int s, input logic v);
    if (s == 0) pad_drv <= v;
    else src[s-1] <= v;
    repeat (4) @(posedge pclk);
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(CCU_OFF_CTRL, 32'h0);
    `CHK(rerr, 1'b0)
    rd(8'h18, 32'h0);
    `CHK(rerr, 1'b1)
    tick(300);
    foreach (cm[i]) begin
      wr(CCU_OFF_CTRL, 32'h0);
      wr(CCU_OFF_CTRL, {24'h0, 4'h8, cm[i]});
      wr(CCU_OFF_IRQ_REQ, 32'h1);
      tick(1);
      drv(0, 1'b1);
      er = cnt;
      tick(1);
      drv(0, 1'b0);
      rdv(cm[i] == CCU_MODE_CAP_RISE ? er : cnt);
      rd(CCU_OFF_IRQ_REQ, 32'h1);
    end
    wr(CCU_OFF_IRQ_EN, 32'h1);
    rd(CCU_OFF_IRQ_EN, 32'h1);
    `CHK(irq, 1'b1)
    wr(CCU_OFF_IRQ_REQ, 32'h1);
    `CHK(irq, 1'b0)
    for (int d = 4; d <= 16; d += 12) begin
      wr(CCU_OFF_CTRL, 32'h0);
      wr(CCU_OFF_CTRL, d == 4 ? 32'h86 : 32'h87);
      drv(0, 1'b1);
      drv(0, 1'b0);
      wr(CCU_OFF_CTRL, 32'h0);
      wr(CCU_OFF_CTRL, d == 4 ? 32'h86 : 32'h87);
      wr(CCU_OFF_IRQ_REQ, 32'h1);
      for (int k = 1; k <= d; k++) begin
        tick(1);
        drv(0, 1'b1);
        drv(0, 1'b0);
        rd(CCU_OFF_IRQ_REQ, 32'(k == d));
      end
      rdv(cnt);
    end
    wr(CCU_OFF_CTRL, 32'h85);
    for (int s = 1; s <= 3; s++) begin
      wr(CCU_OFF_CAPSEL, 32'(s));
      wr(CCU_OFF_IRQ_REQ, 32'h1);
      drv(0, 1'b1);
      drv(0, 1'b0);
      rd(CCU_OFF_IRQ_REQ, 32'h0);
      tick(1);
      drv(s, 1'b1);
      drv(s, 1'b0);
      rdv(cnt);
    end
    wr(CCU_OFF_CAPSEL, 32'h0);
    wr(CCU_OFF_CTRL, 32'h0);
    foreach (km[i]) begin
      wv(cnt + 16'h0002);
      wr(CCU_OFF_CTRL, {24'h0, 4'h8, km[i]});
      wr(CCU_OFF_IRQ_REQ, 32'h1);
      hi_cnt = 0;
      tick(2);
      if (km[i] inside {CCU_MODE_CMP_TGLCL, CCU_MODE_CMP_PLSCL}) cnt = 16'h0;
      if (km[i] inside {CCU_MODE_CMP_TGLCL, CCU_MODE_CMP_TGL}) eo = !eo;
      else eo = (km[i] == CCU_MODE_CMP_SET);
      rd(CCU_OFF_IRQ_REQ, 32'h1);
      `CHK(link.chan_out, eo)
      if (km[i] >= CCU_MODE_CMP_PULSE) `CHK(hi_cnt, CCU_PULSE_CYC)
    end
    wr(CCU_OFF_CAPSEL, 32'h80);
    rd(CCU_OFF_CAPSEL, 32'h80);
    wv(cnt + 16'h0002);
    wr(CCU_OFF_CTRL, 32'h88);
    tick(2);
    rd(CCU_OFF_CTRL, 32'hA8);
    `CHK({link.chan_out, link.chan_oe}, 2'b00)
    wr(CCU_OFF_CTRL, 32'h0);
    rd(CCU_OFF_CTRL, 32'h0);
    // Instruction tick: two captures 16 pclk apart differ by a fixed step
    tsel <= 1'b0;
    wr(CCU_OFF_CTRL, 32'h85);
    drv(0, 1'b1);
    drv(0, 1'b0);
    xfer(CCU_OFF_VAL_LO, 1'b0, 32'h0);
    er[7:0] = rdat[7:0];
    xfer(CCU_OFF_VAL_HI, 1'b0, 32'h0);
    er[15:8] = rdat[7:0];
    repeat (2) @(posedge pclk);
    drv(0, 1'b1);
    rdv(er + 16'(16 / CCU_INSTR_DIV));
    final_report;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    final_report;
  end
endmodule
